/* hw/fan_cfg_pkg.sv */
// constants shared by the fan monitor configuration and status register bank
package fan_cfg_pkg;
    // ======================================================================
    // register indices (byte address is four times the index)
    localparam logic [5:0] IDX_CONFIG      = 6'h01;
    localparam logic [5:0] IDX_FAN_CAP     = 6'h02;
    localparam logic [5:0] IDX_FANS_INST   = 6'h03;
    localparam logic [5:0] IDX_PIN_CAP     = 6'h04;
    localparam logic [5:0] IDX_PIN_USE     = 6'h05;
    localparam logic [5:0] IDX_SENSORS     = 6'h06;
    localparam logic [5:0] IDX_FORCE_ALARM = 6'h07;
    localparam logic [5:0] IDX_FORCE_HOT   = 6'h08;
    localparam logic [5:0] IDX_FORCE_FULL  = 6'h09;
    localparam logic [5:0] IDX_SW_RESET    = 6'h0b;
    localparam logic [5:0] IDX_SPINUP      = 6'h0c;
    localparam logic [5:0] IDX_MAKER       = 6'h0d;
    localparam logic [5:0] IDX_REVISION    = 6'h0e;
    localparam logic [5:0] IDX_FACT_TEST   = 6'h0f;
    localparam logic [5:0] IDX_FAN0_STATE  = 6'h10;
    localparam logic [5:0] IDX_FAN1_STATE  = 6'h11;
    // ======================================================================
    // config bit positions
    localparam int CFG_INSTALL   = 0;
    localparam int CFG_ALERT_MSK = 1;
    localparam int CFG_ARA_DIS   = 2;
    localparam int CFG_FREEWHEEL = 3;
    localparam int CFG_MONITOR   = 4;
    localparam int CFG_FORCE_CF  = 5;
    localparam int CFG_FORCE_AL  = 6;
    localparam int CFG_ALERT_POL = 7;
    // fan state flag positions
    localparam int FS_MISSING   = 0;
    localparam int FS_MISSING_L = 1;
    localparam int FS_FAULT     = 2;
    localparam int FS_FAULT_L   = 3;
    // ======================================================================
    // constant read values and values after reset
    localparam logic [7:0] FAN_CAP_VAL    = 8'h03;
    localparam logic [7:0] PIN_CAP_VAL    = 8'h7f;
    localparam logic [6:0] PIN_USE_RESET  = 7'h07;
    localparam logic [3:0] SPINUP_RESET   = 4'h3;
    localparam logic [7:0] SW_RESET_KEY   = 8'ha6;
    localparam logic [7:0] ZERO_BYTE      = 8'h00;
    // arbitrary neutral identity values
    localparam logic [7:0] MAKER_DEFAULT  = 8'h5a;
    localparam logic [7:0] REV_DEFAULT    = 8'h12;
    // ======================================================================
    // timing
    localparam longint CLK_HZ            = 10_000_000;
    localparam longint FREEWHEEL_TIME_MS = 10_000;
    localparam longint FREEWHEEL_CYC     = FREEWHEEL_TIME_MS * CLK_HZ / 1000;
    // ======================================================================
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* hw/fan_monitor_config_status_regs.sv */
// configuration, capability, command and fan status register bank over axi4-lite
// How it works
// - global alert mask bit set keeps host alert output deasserted for alert requests; config bit 6 still forces it.
// - config bit 2 set withdraws the device from alert response address use.
// - writing config bit 3 runs a ten second free-wheel test, pausing monitoring.
// - config bit 4 starts monitoring; while clear all fans run at alarm speed.
// - monitoring start bit is loaded from the automatic fan control strap at power-up.
// - config bit 5 drives the cascade fault line low regardless of sources.
// - config bit 6 forces the host alert output to its asserted level.
// - config bit 7 picks alert level: 1 active high, 0 active low.
// - config bit 0 and installed-fans bit 1 are one shared stored bit.
// - fan capability reads 03h, pin capability reads 7Fh, upper bits zero.
// - installed-fans bit 0 resets to 1, bit 1 taken from strap; both writable.
// - pin-use bits 0 to 2 reset to 1; clearing bit 0 or 1 selects analog input.
// - pin-use diode bits cleared if diode detected at power-up, else set; writable.
// - installed sensors is read-only: bit 0 fixed 1, bits 1-2 detected diodes.
// - force alarm bits 0 and 1 put fan 0 or fan 1 at alarm speed.
// - force hot-plug bits 0 and 1 put fan 0 or fan 1 at hot-plug speed.
// - force full bits 0 and 1 put fan 0 or fan 1 at full speed.
// - writing A6h to software reset acts as power-on reset; reads back zero.
// - spin-up bit 3 disables spin-up; bits 2-0 select spin-up time code.
// - read-only maker code and revision with minor low nibble, major high nibble.
// - fan flag bit 0 follows missing pin; bit 1 latches removal until written 0.
// - bit 2 inverts fault pin; bit 3 latches fault, cleared by write 0 or absence.
//
// Chosen here: the AXI4-Lite slave port.
module fan_monitor_config_status_regs
    import fan_cfg_pkg::*;
#(
    parameter int         NUM_FANS         = 2,
    parameter longint     FREEWHEEL_CYCLES = FREEWHEEL_CYC,
    parameter logic [7:0] MAKER_CODE       = MAKER_DEFAULT,
    parameter logic [7:0] REVISION_CODE    = REV_DEFAULT
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                auto_fan_strap,
    input  wire logic                remote_diode_one,
    input  wire logic                remote_diode_two,
    input  wire logic [NUM_FANS-1:0] fan_missing,
    input  wire logic [NUM_FANS-1:0] fan_fault_n,
    input  wire logic                alert_request,
    input  wire logic                fault_request,
    output logic                     host_alert,
    output logic                     ara_enable,
    output logic                     cascade_fault_line_n,
    output logic                     monitor_run,
    output logic                     freewheel_active,
    output logic [NUM_FANS-1:0]      fan_alarm_speed,
    output logic [NUM_FANS-1:0]      fan_hotplug_speed,
    output logic [NUM_FANS-1:0]      fan_full_speed,
    output logic                     spinup_disable,
    output logic [2:0]               spinup_time,
    output logic [6:0]               pin_use,
    output logic                     soft_reset_pulse
);

    // ======================================================================
    // reset: soft reset re-enters the power-on state but leaves the bus alone,
    // so the write that triggered it still gets its response
    logic        soft_rst_r;
    logic        rst;
    assign rst = !aresetn || soft_rst_r;

    // ======================================================================
    // axi write channel
    logic        aw_got_r;
    logic        w_got_r;
    logic [5:0]  wr_idx_r;
    logic [7:0]  wr_data_r;
    logic        wr_lane_r;
    logic        wr_en;
    logic        wr_ok;
    logic [5:0]  ar_idx;
    logic [7:0]  rd_byte;
    logic        rd_ok;

    assign wr_en = aw_got_r && w_got_r && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            wr_idx_r      <= 6'h00;
            wr_data_r     <= ZERO_BYTE;
            wr_lane_r     <= 1'b0;
        end else begin
            if (!aw_got_r && !s_axi_bvalid) begin
                s_axi_awready <= !(s_axi_awvalid && s_axi_awready);
            end
            if (!w_got_r && !s_axi_bvalid) begin
                s_axi_wready <= !(s_axi_wvalid && s_axi_wready);
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r      <= 1'b1;
                s_axi_awready <= 1'b0;
                wr_idx_r      <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r      <= 1'b1;
                s_axi_wready <= 1'b0;
                wr_data_r    <= s_axi_wdata[7:0];
                wr_lane_r    <= s_axi_wstrb[0];
            end
            if (wr_en) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // ======================================================================
    // axi read channel: answer one cycle after the address is taken
    assign ar_idx = s_axi_araddr[7:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            if (!s_axi_rvalid) begin
                s_axi_arready <= !(s_axi_arvalid && s_axi_arready);
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= {24'h00_0000, rd_byte};
                s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ======================================================================
    // register storage
    logic [7:0]          cfg_r;
    logic                fan0_inst_r;
    logic [6:0]          pin_use_r;
    logic [1:0]          sensors_r;
    logic [1:0]          frc_alarm_r;
    logic [1:0]          frc_hot_r;
    logic [1:0]          frc_full_r;
    logic [3:0]          spinup_r;
    logic [7:0]          fact_test_r;
    logic                strap_load_r;
    logic [31:0]         fw_count_r;
    logic [NUM_FANS-1:0] miss_r;
    logic [NUM_FANS-1:0] miss_l_r;
    logic [NUM_FANS-1:0] fault_r;
    logic [NUM_FANS-1:0] fault_l_r;

    function automatic logic hit(input logic [5:0] idx);
        hit = wr_en && wr_lane_r && (wr_idx_r == idx);
    endfunction

    // straps are caught on the first edge after reset lets go
    always_ff @(posedge aclk) begin
        if (rst) begin
            strap_load_r <= 1'b1;
        end else begin
            strap_load_r <= 1'b0;
        end
    end

    // only the bus reset clears these, so the outward pulse outlives the soft reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_rst_r       <= 1'b0;
            soft_reset_pulse <= 1'b0;
        end else begin
            soft_rst_r       <= hit(IDX_SW_RESET) && (wr_data_r == SW_RESET_KEY);
            soft_reset_pulse <= soft_rst_r;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            cfg_r       <= ZERO_BYTE;
            fan0_inst_r <= 1'b1;
            pin_use_r   <= PIN_USE_RESET;
            sensors_r   <= 2'b00;
        end else if (strap_load_r) begin
            cfg_r[CFG_MONITOR] <= auto_fan_strap;
            cfg_r[CFG_INSTALL] <= auto_fan_strap;
            pin_use_r[4:3]     <= {2{!remote_diode_one}};
            pin_use_r[6:5]     <= {2{!remote_diode_two}};
            sensors_r          <= {remote_diode_two, remote_diode_one};
        end else begin
            if (hit(IDX_CONFIG)) begin
                cfg_r[7:4] <= wr_data_r[7:4];
                cfg_r[2:0] <= wr_data_r[2:0];
                // a running test cannot be restarted or cut short by software
                if (!cfg_r[CFG_FREEWHEEL]) begin
                    cfg_r[CFG_FREEWHEEL] <= wr_data_r[CFG_FREEWHEEL];
                end
            end else if (hit(IDX_FANS_INST)) begin
                cfg_r[CFG_INSTALL] <= wr_data_r[1];
            end
            if (cfg_r[CFG_FREEWHEEL] && (fw_count_r == 32'(FREEWHEEL_CYCLES - 1))) begin
                cfg_r[CFG_FREEWHEEL] <= 1'b0;
            end
            if (hit(IDX_FANS_INST)) begin
                fan0_inst_r <= wr_data_r[0];
            end
            if (hit(IDX_PIN_USE)) begin
                pin_use_r <= wr_data_r[6:0];
            end
        end
    end

    // free-wheel test timer
    always_ff @(posedge aclk) begin
        if (rst || !cfg_r[CFG_FREEWHEEL]) begin
            fw_count_r <= 32'h0000_0000;
        end else begin
            fw_count_r <= fw_count_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst) begin
            frc_alarm_r <= 2'b00;
            frc_hot_r   <= 2'b00;
            frc_full_r  <= 2'b00;
            spinup_r    <= SPINUP_RESET;
            fact_test_r <= ZERO_BYTE;
        end else begin
            if (hit(IDX_FORCE_ALARM)) begin
                frc_alarm_r <= wr_data_r[1:0];
            end
            if (hit(IDX_FORCE_HOT)) begin
                frc_hot_r <= wr_data_r[1:0];
            end
            if (hit(IDX_FORCE_FULL)) begin
                frc_full_r <= wr_data_r[1:0];
            end
            if (hit(IDX_SPINUP)) begin
                spinup_r <= wr_data_r[3:0];
            end
            if (hit(IDX_FACT_TEST)) begin
                fact_test_r <= wr_data_r;
            end
        end
    end

    // ======================================================================
    // fan presence and fault flags; a set beats a software clear in one cycle
    always_ff @(posedge aclk) begin
        if (rst) begin
            miss_r    <= '0;
            miss_l_r  <= '0;
            fault_r   <= '0;
            fault_l_r <= '0;
        end else begin
            for (int i = 0; i < NUM_FANS; i++) begin
                logic clr_wr;
                logic clr_bits;
                clr_wr   = hit(IDX_FAN0_STATE + 6'(i));
                clr_bits = 1'b0;
                miss_r[i]  <= fan_missing[i];
                fault_r[i] <= !fan_fault_n[i];
                if (fan_missing[i] && !miss_r[i]) begin
                    miss_l_r[i] <= 1'b1;
                end else if (clr_wr && !wr_data_r[FS_MISSING_L]) begin
                    miss_l_r[i] <= 1'b0;
                end
                clr_bits = clr_wr && !wr_data_r[FS_FAULT_L];
                // absence clears the fault latch even against a new fault edge
                if (fan_missing[i]) begin
                    fault_l_r[i] <= 1'b0;
                end else if (!fan_fault_n[i] && !fault_r[i]) begin
                    fault_l_r[i] <= 1'b1;
                end else if (clr_bits) begin
                    fault_l_r[i] <= 1'b0;
                end
            end
        end
    end

    // ======================================================================
    // read mux; unused bits read zero
    always_comb begin
        rd_byte = ZERO_BYTE;
        rd_ok   = 1'b1;
        case (ar_idx)
            IDX_CONFIG:      rd_byte = cfg_r;
            IDX_FAN_CAP:     rd_byte = FAN_CAP_VAL;
            IDX_FANS_INST:   rd_byte = {6'h00, cfg_r[CFG_INSTALL], fan0_inst_r};
            IDX_PIN_CAP:     rd_byte = PIN_CAP_VAL;
            IDX_PIN_USE:     rd_byte = {1'b0, pin_use_r};
            IDX_SENSORS:     rd_byte = {5'h00, sensors_r, 1'b1};
            IDX_FORCE_ALARM: rd_byte = {6'h00, frc_alarm_r};
            IDX_FORCE_HOT:   rd_byte = {6'h00, frc_hot_r};
            IDX_FORCE_FULL:  rd_byte = {6'h00, frc_full_r};
            IDX_SW_RESET:    rd_byte = ZERO_BYTE;
            IDX_SPINUP:      rd_byte = {4'h0, spinup_r};
            IDX_MAKER:       rd_byte = MAKER_CODE;
            IDX_REVISION:    rd_byte = REVISION_CODE;
            IDX_FACT_TEST:   rd_byte = fact_test_r;
            IDX_FAN0_STATE:  rd_byte = {4'h0, fault_l_r[0], fault_r[0], miss_l_r[0], miss_r[0]};
            IDX_FAN1_STATE:  rd_byte = {4'h0, fault_l_r[1], fault_r[1], miss_l_r[1], miss_r[1]};
            default:         rd_ok   = 1'b0;
        endcase
    end

    always_comb begin
        wr_ok = 1'b1;
        case (wr_idx_r)
            IDX_CONFIG, IDX_FAN_CAP, IDX_FANS_INST, IDX_PIN_CAP, IDX_PIN_USE,
            IDX_SENSORS, IDX_FORCE_ALARM, IDX_FORCE_HOT, IDX_FORCE_FULL,
            IDX_SW_RESET, IDX_SPINUP, IDX_MAKER, IDX_REVISION, IDX_FACT_TEST,
            IDX_FAN0_STATE, IDX_FAN1_STATE: wr_ok = 1'b1;
            default:                        wr_ok = 1'b0;
        endcase
    end

    // ======================================================================
    // outputs, all registered
    logic alert_on;
    assign alert_on = cfg_r[CFG_FORCE_AL] || (alert_request && !cfg_r[CFG_ALERT_MSK]);

    always_ff @(posedge aclk) begin
        if (rst) begin
            host_alert           <= 1'b1;
            ara_enable           <= 1'b1;
            cascade_fault_line_n <= 1'b1;
            monitor_run          <= 1'b0;
            freewheel_active     <= 1'b0;
            fan_alarm_speed      <= '1;
            fan_hotplug_speed    <= '0;
            fan_full_speed       <= '0;
            spinup_disable       <= 1'b0;
            spinup_time          <= 3'h3;
            pin_use              <= PIN_USE_RESET;
        end else begin
            host_alert           <= alert_on ? cfg_r[CFG_ALERT_POL] : !cfg_r[CFG_ALERT_POL];
            ara_enable           <= !cfg_r[CFG_ARA_DIS];
            cascade_fault_line_n <= !(cfg_r[CFG_FORCE_CF] || fault_request);
            monitor_run          <= cfg_r[CFG_MONITOR] && !cfg_r[CFG_FREEWHEEL];
            freewheel_active     <= cfg_r[CFG_FREEWHEEL];
            for (int i = 0; i < NUM_FANS; i++) begin
                fan_alarm_speed[i]   <= frc_alarm_r[i] || !cfg_r[CFG_MONITOR];
                fan_hotplug_speed[i] <= frc_hot_r[i];
                fan_full_speed[i]    <= frc_full_r[i];
            end
            spinup_disable       <= spinup_r[3];
            spinup_time          <= spinup_r[2:0];
            pin_use              <= pin_use_r;
        end
    end

endmodule

/* verif/fan_pins_model.sv */
// far-side fan hardware model: presence switches and fault lines of both fans
module fan_pins_model (
    input  wire logic [1:0] pull,
    input  wire logic [1:0] brk,
    input  wire logic       aclk,
    output logic [1:0]      fan_missing = 2'b00,
    output logic [1:0]      fan_fault_n = 2'b11
);
    timeunit 1ns;
    timeprecision 1ns;
    // pins move just after an edge, never while the bank samples them
    always @(posedge aclk) begin
        fan_missing <= pull;
        fan_fault_n <= ~brk;
    end
endmodule

/* verif/fan_cfg_monitor.sv */
// port-level checks for the fan monitor register bank
module fan_cfg_monitor #(
    parameter longint FREEWHEEL_CYCLES = 20
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        monitor_run,
    input wire logic        freewheel_active,
    input wire logic [1:0]  fan_alarm_speed,
    input wire logic        soft_reset_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // =========================================================
    // helper: length of the current free-wheel run
    longint fw_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !freewheel_active) fw_cnt_r <= 0;
        else fw_cnt_r <= fw_cnt_r + 1;
    end
    // =========================================================
    // checks
    chk_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("awready high after beat");
    chk_rd_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read data not zero");
    chk_idle_alarm: assert property (!monitor_run && !freewheel_active |-> fan_alarm_speed == 2'b11)
        else $error("fans not at alarm speed when stopped");
    chk_fw_pause: assert property (freewheel_active |-> !monitor_run)
        else $error("monitoring during free-wheel test");
    chk_fw_hold: assert property ($rose(freewheel_active) |-> freewheel_active[*8])
        else $error("free-wheel test ended too early");
    chk_fw_len: assert property (freewheel_active |-> fw_cnt_r <= FREEWHEEL_CYCLES)
        else $error("free-wheel test too long");
    chk_srst_pulse: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("soft reset pulse too long");
    cover property ($rose(freewheel_active));
    cover property (soft_reset_pulse);
    cover property (!monitor_run && !freewheel_active);
endmodule

bind fan_monitor_config_status_regs fan_cfg_monitor #(.FREEWHEEL_CYCLES(FREEWHEEL_CYCLES)) mon (.*);

/* verif/tb.sv */
// self-checking bench for the fan monitor configuration and status registers
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fan_cfg_pkg::*;
    localparam longint FW = 20;
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, auto_fan_strap = 1, alert_request = 0;
    logic remote_diode_one = 1, remote_diode_two = 0, fault_request = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic host_alert, ara_enable, cascade_fault_line_n, monitor_run, freewheel_active;
    logic spinup_disable, soft_reset_pulse;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rs, fan_missing, fan_fault_n;
    logic [1:0]  fan_pull = '0, fan_brk = '0, fan_alarm_speed, fan_hotplug_speed, fan_full_speed;
    logic [2:0]  spinup_time;
    logic [6:0]  pin_use;
    int          bad_count = 0, n_compared = 0, n;
    wire [16:0]  fan_out = {fan_alarm_speed, fan_hotplug_speed, fan_full_speed, spinup_disable,
        spinup_time, pin_use};

    fan_monitor_config_status_regs #(.FREEWHEEL_CYCLES(FW)) dut (.*);
    fan_pins_model fan_side (.aclk, .pull(fan_pull), .brk(fan_brk), .fan_missing, .fan_fault_n);

    always #50 aclk = ~aclk;
    // =========================================================
    // bus tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] ix, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {ix, 2'b00};
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 0;
        rs = s_axi_bresp;
    endtask
    task automatic rd_reg(input logic [5:0] ix);
        @(posedge aclk);
        s_axi_araddr <= {ix, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 0;
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask
    task automatic chk_reg(input logic [5:0] ix, input logic [7:0] e);
        rd_reg(ix);
        cmp($sformatf("register %h", ix), {24'h00_0000, e}, rd);
    endtask
    task automatic pins(input logic [1:0] p, input logic [1:0] b);
        fan_pull <= p;
        fan_brk <= b;
        repeat (3) @(posedge aclk);
    endtask
    // =========================================================
    // scenarios
    task automatic t_defaults;
        logic [13:0] tab [16] = '{14'h0111, 14'h0203, 14'h0303, 14'h047f, 14'h0567, 14'h0603,
            14'h0700, 14'h0800, 14'h0900, 14'h0b00, 14'h0c03, {6'h0d, MAKER_DEFAULT},
            {6'h0e, REV_DEFAULT}, 14'h0f00, 14'h1000, 14'h1100};
        foreach (tab[i]) chk_reg(tab[i][13:8], tab[i][7:0]);
        rd_reg(6'h3f);
        cmp("unmapped read", RESP_SLVERR, rs);
        wr(6'h3f, 8'hff);
        cmp("unmapped write", RESP_SLVERR, rs);
    endtask
    task automatic t_outputs;
        logic [13:0] tab [7] = '{{8'h10, 6'b011100}, {8'h12, 6'b111100}, {8'h52, 6'b011100},
            {8'h92, 6'b011100}, {8'hd2, 6'b111100}, {8'h94, 6'b101100}, {8'h20, 6'b010011}};
        alert_request <= 1;
        foreach (tab[i]) begin
            wr(IDX_CONFIG, tab[i][13:6]);
            @(posedge aclk);
            cmp("pin outputs", tab[i][5:0], {host_alert, ara_enable, cascade_fault_line_n,
                monitor_run, fan_alarm_speed});
        end
        alert_request <= 0;
        chk_reg(IDX_FANS_INST, 8'h01);
        wr(IDX_FANS_INST, 8'h03);
        chk_reg(IDX_CONFIG, 8'h21);
    endtask
    task automatic t_writes;
        logic [13:0] tab [12] = '{14'h0203, 14'h0303, 14'h047f, 14'h057f, 14'h0603, 14'h0703,
            14'h0803, 14'h0903, 14'h0c0f, {6'h0d, MAKER_DEFAULT}, {6'h0e, REV_DEFAULT},
            14'h0b00};
        wr(IDX_CONFIG, 8'h11);
        foreach (tab[i]) begin
            wr(tab[i][13:8], 8'hff);
            chk_reg(tab[i][13:8], tab[i][7:0]);
        end
        cmp("fan outputs", 17'h1_ffff, fan_out);
        wr(IDX_FORCE_ALARM, 8'h01);
        wr(IDX_FORCE_HOT, 8'h02);
        wr(IDX_FORCE_FULL, 8'h00);
        wr(IDX_SPINUP, 8'h05);
        wr(IDX_PIN_USE, 8'h7c);
        @(posedge aclk);
        cmp("fan outputs", 17'h0_c2fc, fan_out);
    endtask
    task automatic t_fans;
        pins(2'b10, 2'b00);
        chk_reg(IDX_FAN1_STATE, 8'h03);
        pins(2'b00, 2'b00);
        chk_reg(IDX_FAN1_STATE, 8'h02);
        wr(IDX_FAN1_STATE, 8'h00);
        chk_reg(IDX_FAN1_STATE, 8'h00);
        pins(2'b00, 2'b01);
        chk_reg(IDX_FAN0_STATE, 8'h0c);
        pins(2'b00, 2'b00);
        chk_reg(IDX_FAN0_STATE, 8'h08);
        wr(IDX_FAN0_STATE, 8'h00);
        chk_reg(IDX_FAN0_STATE, 8'h00);
        pins(2'b01, 2'b01);
        chk_reg(IDX_FAN0_STATE, 8'h07);
        pins(2'b00, 2'b00);
        wr(IDX_FAN0_STATE, 8'h00);
        chk_reg(IDX_FAN0_STATE, 8'h00);
    endtask
    task automatic t_freewheel;
        wr(IDX_CONFIG, 8'h18);
        @(posedge aclk);
        cmp("test running", 2'b10, {freewheel_active, monitor_run});
        n = 0;
        while (freewheel_active === 1 && n < 100) begin
            @(posedge aclk);
            n++;
        end
        cmp("test length", 32'(FW), n);
        chk_reg(IDX_CONFIG, 8'h10);
    endtask
    task automatic t_soft;
        wr(IDX_FACT_TEST, 8'h5a);
        auto_fan_strap <= 0;
        wr(IDX_SW_RESET, 8'ha6);
        @(posedge aclk);
        cmp("soft reset pulse", 1, soft_reset_pulse);
        chk_reg(IDX_SW_RESET, 8'h00);
        chk_reg(IDX_FACT_TEST, 8'h00);
        chk_reg(IDX_CONFIG, 8'h00);
        chk_reg(IDX_FANS_INST, 8'h01);
    endtask
    // =========================================================
    // run control
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1;
        t_defaults;
        t_outputs;
        t_writes;
        t_fans;
        t_freewheel;
        t_soft;
        finish_test;
    end
    // a pass needs under 2,000 cycles
    initial begin
        repeat (20000) @(posedge aclk);
        bad_count++;
        finish_test;
    end
endmodule
